/* File: src/product_info_consts.vh */
// constants for the product information capability and its serial storage port
// assumes a 10 MHz reference clock and a byte-addressed serial storage part
`ifndef PRODUCT_INFO_CONSTS_VH
`define PRODUCT_INFO_CONSTS_VH

// ----------------------------------------
// capability layout
// ----------------------------------------
`define CAP_TYPE_CODE 8'h03
`define NEXT_CAP_PTR 8'h00
`define OFS_CAP_HEADER 8'h00
`define OFS_DATA_WINDOW 8'h04
`define ADDR_LSB 16
`define ADDR_MSB 30
`define FLAG_BIT 31
`define ADDR_RESET 15'h0000
`define DATA_RESET 32'h00000000

// ----------------------------------------
// stored content tags
// ----------------------------------------
`define TAG_LARGE_BIT 7
`define TAG_ID_STRING 8'h82
`define TAG_READONLY 8'h90
`define TAG_WRITABLE 8'h91
`define TAG_END 8'h78
`define LARGE_HDR_LEN 15'h0003
`define KEYWORD_CHAR_LO 8'h30
`define KEYWORD_CHAR_HI 8'h5A

// ----------------------------------------
// serial storage commands and timing
// ----------------------------------------
`define CMD_READ 8'h03
`define CMD_WRITE 8'h02
`define CMD_WRITE_ENABLE 8'h06
`define CLK_PERIOD_NS 100
`define SCK_HALF_NS 400
`define SCK_HALF_CYCLES (`SCK_HALF_NS / `CLK_PERIOD_NS)
`define WRITE_CYCLE_US 5000
`define WRITE_CYCLE_CYCLES ((`WRITE_CYCLE_US * 1000) / `CLK_PERIOD_NS)

`endif

/* File: src/storage_serial_port.v */
// serial storage port: moves one four-byte group to or from the storage part
// assumes a mode-0 serial part with write-enable, read and page write commands
`timescale 1ns/1ps
`include "product_info_consts.vh"

module storage_serial_port #(
	parameter [15:0] WRITE_WAIT = `WRITE_CYCLE_CYCLES
) (
	// clock and reset
	input wire ref_clk_in,
	input wire reset_n_in,
	// request
	input wire start_in,
	input wire write_in,
	input wire [14:0] addr_in,
	input wire [31:0] wdata_in,
	// answer
	output reg [31:0] rdata_out,
	output reg done_out,
	// storage pins
	output reg sclk_out,
	output reg select_n_out,
	output reg mosi_out,
	input wire miso_in
);

	localparam E_IDLE = 3'd0;
	localparam E_SHIFT = 3'd1;
	localparam E_GAP = 3'd2;
	localparam E_WAIT = 3'd3;
	localparam [31:0] HALF_CYCLES = `SCK_HALF_CYCLES - 1;
	localparam [2:0] HALF_LAST = HALF_CYCLES[2:0];

	reg [2:0] state;
	reg [2:0] hc;
	reg [2:0] bi;
	reg [2:0] bt;
	reg [2:0] last;
	reg [7:0] cmd;
	reg [7:0] rx;
	reg [14:0] addr_q;
	reg [31:0] wdata_q;
	reg write_q;
	reg wren_phase;
	reg [15:0] wait_cnt;
	reg miso_meta;
	reg miso_s;
	wire [7:0] rx_byte;
	wire [7:0] cur_tx;
	wire [7:0] nxt_tx;

	// ----------------------------------------
	// byte stream
	// ----------------------------------------
	function [7:0] tx_byte;
		input [2:0] i;
		begin
			case (i)
				3'd0: tx_byte = cmd;
				3'd1: tx_byte = {1'b0, addr_q[14:8]};
				3'd2: tx_byte = addr_q[7:0];
				3'd3: tx_byte = wdata_q[7:0];
				3'd4: tx_byte = wdata_q[15:8];
				3'd5: tx_byte = wdata_q[23:16];
				default: tx_byte = wdata_q[31:24];
			endcase
		end
	endfunction

	assign rx_byte = {rx[6:0], miso_s};
	assign cur_tx = tx_byte(bi);
	assign nxt_tx = tx_byte(bi + 3'd1);

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			miso_meta <= 1'b0;
			miso_s <= 1'b0;
		end else begin
			miso_meta <= miso_in;
			miso_s <= miso_meta;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= E_IDLE;
			hc <= 3'd0;
			bi <= 3'd0;
			bt <= 3'd7;
			last <= 3'd0;
			cmd <= 8'h00;
			rx <= 8'h00;
			addr_q <= 15'h0000;
			wdata_q <= 32'h00000000;
			write_q <= 1'b0;
			wren_phase <= 1'b0;
			wait_cnt <= 16'h0000;
			rdata_out <= 32'h00000000;
			done_out <= 1'b0;
			sclk_out <= 1'b0;
			select_n_out <= 1'b1;
			mosi_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state)
				E_IDLE: begin
					if (start_in) begin
						addr_q <= addr_in;
						wdata_q <= wdata_in;
						write_q <= write_in;
						wren_phase <= write_in;
						cmd <= write_in ? `CMD_WRITE_ENABLE : `CMD_READ;
						last <= write_in ? 3'd0 : 3'd6;
						mosi_out <= write_in ? 1'b0 : 1'b0;
						bi <= 3'd0;
						bt <= 3'd7;
						hc <= 3'd0;
						select_n_out <= 1'b0;
						state <= E_SHIFT;
					end
				end
				E_SHIFT: begin
					if (hc == HALF_LAST) begin
						hc <= 3'd0;
						if (!sclk_out) begin
							sclk_out <= 1'b1;
						end else begin
							// sample late in the high phase to cover the synchroniser
							sclk_out <= 1'b0;
							rx <= rx_byte;
							if (bt != 3'd0) begin
								bt <= bt - 3'd1;
								mosi_out <= cur_tx[bt - 3'd1];
							end else begin
								if (!write_q && bi >= 3'd3) begin
									rdata_out[8 * (bi - 3'd3) +: 8] <= rx_byte;
								end
								if (bi == last) begin
									select_n_out <= 1'b1;
									mosi_out <= 1'b0;
									state <= wren_phase ? E_GAP : (write_q ? E_WAIT : E_IDLE);
									done_out <= !wren_phase && !write_q;
									wait_cnt <= 16'h0000;
								end else begin
									bi <= bi + 3'd1;
									bt <= 3'd7;
									mosi_out <= nxt_tx[7];
								end
							end
						end
					end else begin
						if (hc == 3'd0 && !sclk_out && bt == 3'd7 && bi == 3'd0) begin
							mosi_out <= cmd[7];
						end
						hc <= hc + 3'd1;
					end
				end
				E_GAP: begin
					if (hc == HALF_LAST) begin
						hc <= 3'd0;
						wren_phase <= 1'b0;
						cmd <= `CMD_WRITE;
						last <= 3'd6;
						bi <= 3'd0;
						bt <= 3'd7;
						select_n_out <= 1'b0;
						state <= E_SHIFT;
					end else begin
						hc <= hc + 3'd1;
					end
				end
				E_WAIT: begin
					// fixed wait instead of status polling keeps the port small
					if (wait_cnt == WRITE_WAIT - 16'h0001) begin
						done_out <= 1'b1;
						state <= E_IDLE;
					end else begin
						wait_cnt <= wait_cnt + 16'h0001;
					end
				end
				default: state <= E_IDLE;
			endcase
		end
	end

endmodule

/* File: src/product_info_capability.v */
// product information capability: configuration registers and storage transfers
// assumes configuration accesses arrive as single-cycle strobes on ref_clk_in
//
// How it works
// - capability type byte is fixed at the product information code.
// - next capability pointer is read-only and reads zero.
// - bits 30 to 16 hold the writable storage byte address.
// - completion flag is loaded by the same byte write as address bits 30 to 24.
// - hardware sets the flag to one only after four bytes land in the data window.
// - flag returns to zero once all four bytes reach the storage.
// - data window low byte matches the storage byte at the address.
// - every transfer moves exactly four bytes.
// - data window honours byte enables on reads and writes.
// - stored content steers only the status outputs and which addresses accept stores.
// - stores into the read-only portion finish without writing storage.
// - small tag byte: bit 7 zero, name bits 6-3, length 2-0.
// - large tag: bit 7 one, seven-bit name, 16-bit length low first.
// - content starts with the name string tag and ends with end tag.
// - read-only keywords under tag 10h, writable keywords under 11h.
// - read-only section bytes, tag and length included, sum to zero.
// - keyword entries start with two ascii characters and a length byte.
`timescale 1ns/1ps
`include "product_info_consts.vh"

module product_info_capability #(
	parameter [15:0] WRITE_WAIT = `WRITE_CYCLE_CYCLES
) (
	// clock and reset
	input wire ref_clk_in,
	input wire reset_n_in,
	// configuration access
	input wire cfg_read_in,
	input wire cfg_write_in,
	input wire [7:0] cfg_offset_in,
	input wire [3:0] cfg_byte_en_in,
	input wire [31:0] cfg_wdata_in,
	output reg [31:0] cfg_rdata_out,
	output reg cfg_rdata_valid_out,
	// storage pins
	output wire storage_sclk_out,
	output wire storage_select_n_out,
	output wire storage_mosi_out,
	input wire storage_miso_in,
	// status
	output reg scan_done_out,
	output reg content_valid_out,
	output reg transfer_busy_out
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam S_SCAN_ID = 3'd0;
	localparam S_SCAN_RO = 3'd1;
	localparam S_SUM = 3'd2;
	localparam S_SCAN_TAIL = 3'd3;
	localparam S_IDLE = 3'd4;
	localparam S_HOST = 3'd5;

	reg [2:0] state;
	reg issued;
	reg eng_start;
	reg eng_write;
	reg [14:0] eng_addr;
	wire [31:0] eng_rdata;
	wire eng_done;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [14:0] storage_byte_address;
	reg transfer_completion_flag;
	reg [31:0] product_info_data_window;
	reg pending;
	reg pending_store;

	// ----------------------------------------
	// scan state
	// ----------------------------------------
	reg [14:0] ptr;
	reg [14:0] ro_end;
	reg [7:0] sum;
	reg sum_ok;
	reg rw_seen;
	wire [7:0] b0;
	wire [7:0] b3;
	wire [14:0] large_len;
	wire [14:0] next_after;
	wire [7:0] next_sum;
	wire hdr_write;
	wire data_write;
	wire store_allowed;
	reg [31:0] read_word;

	assign b0 = eng_rdata[7:0];
	assign b3 = eng_rdata[31:24];
	assign large_len = eng_rdata[22:8];
	assign next_after = ptr + `LARGE_HDR_LEN + large_len;
	assign next_sum = sum + b0;
	assign hdr_write = cfg_write_in && cfg_offset_in == `OFS_CAP_HEADER;
	assign data_write = cfg_write_in && cfg_offset_in == `OFS_DATA_WINDOW;
	// writable area starts right after the read-only section
	assign store_allowed = content_valid_out && storage_byte_address >= ro_end;

	// ----------------------------------------
	// storage engine
	// ----------------------------------------
	storage_serial_port #(
		.WRITE_WAIT(WRITE_WAIT)
	) storage_serial_port_inst (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.start_in(eng_start),
		.write_in(eng_write),
		.addr_in(eng_addr),
		.wdata_in(product_info_data_window),
		.rdata_out(eng_rdata),
		.done_out(eng_done),
		.sclk_out(storage_sclk_out),
		.select_n_out(storage_select_n_out),
		.mosi_out(storage_mosi_out),
		.miso_in(storage_miso_in)
	);

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always @* begin
		read_word = 32'h00000000;
		if (cfg_offset_in == `OFS_CAP_HEADER) begin
			read_word = {transfer_completion_flag, storage_byte_address,
				`NEXT_CAP_PTR, `CAP_TYPE_CODE};
		end else if (cfg_offset_in == `OFS_DATA_WINDOW) begin
			read_word = product_info_data_window;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : rd_lane
			// reads only sample registers, nothing else changes
			always @(posedge ref_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					cfg_rdata_out[8 * g +: 8] <= 8'h00;
				end else if (cfg_read_in) begin
					cfg_rdata_out[8 * g +: 8] <= cfg_byte_en_in[g] ?
						read_word[8 * g +: 8] : 8'h00;
				end
			end
		end
	endgenerate

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_rdata_valid_out <= 1'b0;
		end else begin
			cfg_rdata_valid_out <= cfg_read_in;
		end
	end

	// ----------------------------------------
	// address, flag and request
	// ----------------------------------------
	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			storage_byte_address <= `ADDR_RESET;
			transfer_completion_flag <= 1'b0;
			pending <= 1'b0;
			pending_store <= 1'b0;
		end else begin
			if (hdr_write && cfg_byte_en_in[2]) begin
				storage_byte_address[7:0] <= cfg_wdata_in[23:16];
			end
			if (hdr_write && cfg_byte_en_in[3]) begin
				storage_byte_address[14:8] <= cfg_wdata_in[`ADDR_MSB:24];
				transfer_completion_flag <= cfg_wdata_in[`FLAG_BIT];
				pending <= 1'b1;
				pending_store <= cfg_wdata_in[`FLAG_BIT];
			end
			if (state == S_IDLE && pending && !(hdr_write && cfg_byte_en_in[3])) begin
				pending <= 1'b0;
			end
			// completion overrides a host write landing in the same cycle
			if (state == S_HOST && eng_done) begin
				transfer_completion_flag <= !eng_write;
			end else if (state == S_IDLE && pending && pending_store && !store_allowed &&
				!(hdr_write && cfg_byte_en_in[3])) begin
				transfer_completion_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// data window
	// ----------------------------------------
	generate
		for (g = 0; g < 4; g = g + 1) begin : wr_lane
			always @(posedge ref_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					product_info_data_window[8 * g +: 8] <= 8'h00;
				end else if (state == S_HOST && eng_done && !eng_write) begin
					// byte g of the window is storage byte address + g
					product_info_data_window[8 * g +: 8] <= eng_rdata[8 * g +: 8];
				end else if (data_write && cfg_byte_en_in[g]) begin
					product_info_data_window[8 * g +: 8] <= cfg_wdata_in[8 * g +: 8];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= S_SCAN_ID;
			issued <= 1'b0;
			eng_start <= 1'b0;
			eng_write <= 1'b0;
			eng_addr <= 15'h0000;
			ptr <= 15'h0000;
			ro_end <= 15'h7FFF;
			sum <= 8'h00;
			sum_ok <= 1'b0;
			rw_seen <= 1'b0;
			scan_done_out <= 1'b0;
			content_valid_out <= 1'b0;
			transfer_busy_out <= 1'b0;
		end else begin
			eng_start <= 1'b0;
			case (state)
				S_SCAN_ID: begin
					if (!issued) begin
						issued <= 1'b1;
						eng_start <= 1'b1;
						eng_write <= 1'b0;
						eng_addr <= 15'h0000;
					end else if (eng_done) begin
						issued <= 1'b0;
						if (b0 == `TAG_ID_STRING) begin
							ptr <= next_after;
							state <= S_SCAN_RO;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_SCAN_RO: begin
					if (!issued) begin
						issued <= 1'b1;
						eng_start <= 1'b1;
						eng_addr <= ptr;
					end else if (eng_done) begin
						issued <= 1'b0;
						if (b0 == `TAG_READONLY && b0[`TAG_LARGE_BIT] &&
							b3 >= `KEYWORD_CHAR_LO && b3 <= `KEYWORD_CHAR_HI) begin
							ro_end <= next_after;
							sum <= 8'h00;
							state <= S_SUM;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_SUM: begin
					// one fetch per byte is slow but needs no alignment logic
					if (!issued) begin
						issued <= 1'b1;
						eng_start <= 1'b1;
						eng_addr <= ptr;
					end else if (eng_done) begin
						issued <= 1'b0;
						sum <= next_sum;
						ptr <= ptr + 15'h0001;
						if (ptr + 15'h0001 == ro_end) begin
							sum_ok <= next_sum == 8'h00;
							state <= S_SCAN_TAIL;
						end
					end
				end
				S_SCAN_TAIL: begin
					if (!issued) begin
						issued <= 1'b1;
						eng_start <= 1'b1;
						eng_addr <= ptr;
					end else if (eng_done) begin
						issued <= 1'b0;
						if (b0 == `TAG_WRITABLE && !rw_seen) begin
							rw_seen <= 1'b1;
							ptr <= next_after;
						end else begin
							// end tag is a small item: name 0Fh, no payload
							content_valid_out <= sum_ok && b0 == `TAG_END &&
								!b0[`TAG_LARGE_BIT];
							state <= S_IDLE;
						end
					end
				end
				S_IDLE: begin
					scan_done_out <= 1'b1;
					transfer_busy_out <= pending;
					if (pending && !(hdr_write && cfg_byte_en_in[3])) begin
						if (!pending_store || store_allowed) begin
							eng_start <= 1'b1;
							eng_write <= pending_store;
							eng_addr <= storage_byte_address;
							state <= S_HOST;
						end
					end
				end
				S_HOST: begin
					transfer_busy_out <= 1'b1;
					if (eng_done) begin
						transfer_busy_out <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule

/* File: test/storage_model.sv */
// serial storage part model: mode 0, read 03h, write enable 06h, page write 02h
// assumes two address bytes and that the host waits out the write time itself
`timescale 1ns/1ps

module storage_model (
	// storage pins
	input wire sclk_in,
	input wire select_n_in,
	input wire mosi_in,
	output reg miso_out
);
	localparam [239:0] IMG = 240'h82_04_00_41_42_43_44_90_04_00_52_56_01_C3_91_0C_00_57_31_09_30_30_30_30_30_30_30_30_30_78;
	reg [7:0] mem [0:63];
	reg [7:0] wbuf [0:7];
	reg [7:0] shift;
	reg [7:0] cmd;
	reg [15:0] addr;
	reg wen;
	integer nbit;
	integer n_writes;
	integer i;
	integer k;
	// ---
	// content image: name tag, read-only section with checksum, writable section, end
	// ---
	initial begin
		miso_out = 1'b0;
		wen = 1'b0;
		cmd = 8'h00;
		nbit = 0;
		n_writes = 0;
		for (i = 0; i < 64; i = i + 1) mem[i] = (i < 30) ? IMG[239 - 8 * i -: 8] : 8'hFF;
	end
	always @(negedge select_n_in) nbit = 0;
	always @(posedge sclk_in) if (!select_n_in) begin
		shift = {shift[6:0], mosi_in};
		nbit = nbit + 1;
		if (nbit == 8) cmd = shift;
		if (nbit == 8 && shift == 8'h06) wen = 1'b1;
		if (nbit == 16) addr[15:8] = shift;
		if (nbit == 24) addr[7:0] = shift;
		if (nbit > 24 && nbit % 8 == 0) wbuf[((nbit - 32) / 8) % 8] = shift;
	end
	// released or idle line toggles so a stale level is never mistaken for data
	always @(negedge sclk_in) if (!select_n_in) begin
		k = nbit - 24;
		if (cmd == 8'h03 && k >= 0) miso_out = mem[(addr + k / 8) % 64][7 - k % 8];
		else miso_out = ~miso_out;
	end
	always @(posedge select_n_in) begin
		if (cmd == 8'h02 && wen && nbit >= 32) begin
			for (i = 0; i < (nbit - 24) / 8; i = i + 1) mem[(addr + i) % 64] = wbuf[i];
			n_writes = n_writes + (nbit - 24) / 8;
			wen = 1'b0;
		end
		cmd = 8'h00;
		miso_out = ~miso_out;
	end
endmodule

/* File: test/product_info_capability_asserts.sv */
// port checker for the product information capability
// assumes one clock domain, bound onto every instance of the top module
`timescale 1ns/1ps

module product_info_capability_asserts (
	// clock and reset
	input wire ref_clk_in,
	input wire reset_n_in,
	// configuration access
	input wire cfg_read_in,
	input wire cfg_write_in,
	input wire [7:0] cfg_offset_in,
	input wire [3:0] cfg_byte_en_in,
	input wire [31:0] cfg_rdata_out,
	input wire cfg_rdata_valid_out,
	// storage pins and status
	input wire storage_sclk_out,
	input wire storage_select_n_out,
	input wire scan_done_out,
	input wire transfer_busy_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	reg [7:0] sclk_count;
	reg sclk_last;
	// counts serial clocks in the current frame
	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sclk_count <= 8'h00;
			sclk_last <= 1'b0;
		end else begin
			sclk_last <= storage_sclk_out;
			if (storage_select_n_out) sclk_count <= 8'h00;
			else if (storage_sclk_out && !sclk_last) sclk_count <= sclk_count + 8'h01;
		end
	end
	sequence s_header_read;
		cfg_read_in && cfg_offset_in == 8'h00;
	endsequence
	sequence s_answer;
		cfg_rdata_valid_out;
	endsequence
	property p_read_answer;
		cfg_read_in |=> s_answer;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	property p_no_stray_answer;
		!cfg_read_in |=> !cfg_rdata_valid_out;
	endproperty
	a_no_stray_answer: assert property (p_no_stray_answer) else $error("stray answer");
	property p_type_code;
		s_header_read ##0 cfg_byte_en_in[0] |=> cfg_rdata_out[7:0] == 8'h03;
	endproperty
	a_type_code: assert property (p_type_code) else $error("wrong type code");
	property p_next_pointer;
		s_header_read ##0 cfg_byte_en_in[1] |=> cfg_rdata_out[15:8] == 8'h00;
	endproperty
	a_next_pointer: assert property (p_next_pointer) else $error("wrong pointer");
	property p_lane_masked;
		cfg_read_in && !cfg_byte_en_in[3] |=> cfg_rdata_out[31:24] == 8'h00;
	endproperty
	a_lane_masked: assert property (p_lane_masked) else $error("disabled lane read");
	property p_data_holds;
		!cfg_read_in |=> $stable(cfg_rdata_out);
	endproperty
	a_data_holds: assert property (p_data_holds) else $error("read data moved");
	property p_launch;
		scan_done_out && !transfer_busy_out && cfg_write_in && cfg_offset_in == 8'h00 &&
			cfg_byte_en_in[3] |=> ##1 transfer_busy_out;
	endproperty
	a_launch: assert property (p_launch) else $error("no transfer launched");
	property p_read_no_launch;
		cfg_read_in && !cfg_write_in && !$past(cfg_write_in) && !transfer_busy_out
			|=> !transfer_busy_out;
	endproperty
	a_read_no_launch: assert property (p_read_no_launch) else $error("read launched");
	property p_sclk_idle;
		storage_select_n_out |-> !storage_sclk_out;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("clock while idle");
	property p_four_bytes;
		$rose(storage_select_n_out) && $past(scan_done_out, 2)
			|-> sclk_count == 8'd8 || sclk_count == 8'd56;
	endproperty
	a_four_bytes: assert property (p_four_bytes) else $error("bad frame length");
endmodule

bind product_info_capability product_info_capability_asserts product_info_capability_asserts_inst (
	.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cfg_read_in(cfg_read_in),
	.cfg_write_in(cfg_write_in), .cfg_offset_in(cfg_offset_in), .cfg_byte_en_in(cfg_byte_en_in),
	.cfg_rdata_out(cfg_rdata_out), .cfg_rdata_valid_out(cfg_rdata_valid_out),
	.storage_sclk_out(storage_sclk_out), .storage_select_n_out(storage_select_n_out),
	.scan_done_out(scan_done_out), .transfer_busy_out(transfer_busy_out));

/* File: test/tb_product_info_capability.sv */
// self-checking bench for the product information capability
// assumes the storage model content image and a shortened write wait
`timescale 1ns/1ps

module tb_product_info_capability;
	reg ref_clk_in;
	reg reset_n_in;
	reg cfg_read_in;
	reg cfg_write_in;
	reg [7:0] cfg_offset_in;
	reg [3:0] cfg_byte_en_in;
	reg [31:0] cfg_wdata_in;
	wire [31:0] cfg_rdata_out;
	wire cfg_rdata_valid_out;
	wire sclk;
	wire sel_n;
	wire mosi;
	wire miso;
	wire scan_done_out;
	wire content_valid_out;
	wire transfer_busy_out;
	integer n_fail;
	integer n_checks;
	integer i;
	int ref_mem[$];
	reg [31:0] rd;
	reg [31:0] wd;

	product_info_capability #(.WRITE_WAIT(16'd20)) product_info_capability_inst (
		.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cfg_read_in(cfg_read_in),
		.cfg_write_in(cfg_write_in), .cfg_offset_in(cfg_offset_in),
		.cfg_byte_en_in(cfg_byte_en_in), .cfg_wdata_in(cfg_wdata_in),
		.cfg_rdata_out(cfg_rdata_out), .cfg_rdata_valid_out(cfg_rdata_valid_out),
		.storage_sclk_out(sclk), .storage_select_n_out(sel_n), .storage_mosi_out(mosi),
		.storage_miso_in(miso), .scan_done_out(scan_done_out),
		.content_valid_out(content_valid_out), .transfer_busy_out(transfer_busy_out));
	storage_model storage_model_inst (.sclk_in(sclk), .select_n_in(sel_n), .mosi_in(mosi),
		.miso_out(miso));

	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// ---
	// compares, bus cycles, transfers
	// ---
	task automatic chk_reg(input [31:0] got, input [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_mem(input integer got, input integer exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR %0t storage %0d expected %0d", $time, got, exp);
		end
	endtask
	// each access lets a full cycle pass so strobes never change twice in one step
	task automatic cfg_wr(input [7:0] off, input [3:0] be, input [31:0] d);
		cfg_write_in = 1'b1;
		cfg_offset_in = off;
		cfg_byte_en_in = be;
		cfg_wdata_in = d;
		@(negedge ref_clk_in);
		cfg_write_in = 1'b0;
		@(negedge ref_clk_in);
	endtask
	task automatic cfg_rd(input [7:0] off, input [3:0] be, output [31:0] d);
		cfg_read_in = 1'b1;
		cfg_offset_in = off;
		cfg_byte_en_in = be;
		@(negedge ref_clk_in);
		// valid stands for one cycle only, so look at it here
		chk_reg({31'h0, cfg_rdata_valid_out}, 32'h1);
		d = cfg_rdata_out;
		cfg_read_in = 1'b0;
		@(negedge ref_clk_in);
	endtask
	task automatic poll(input f, input [14:0] adr);
		integer n;
		n = 0;
		rd = {~f, 31'h0};
		while (rd[31] !== f && n < 600) begin
			cfg_rd(8'h00, 4'hF, rd);
			n = n + 1;
		end
		chk_reg(rd, {f, adr, 16'h0003});
	endtask
	task automatic fetch(input [14:0] adr);
		integer j;
		reg [31:0] e;
		cfg_wr(8'h00, 4'hC, {1'b0, adr, 16'h0});
		poll(1'b1, adr);
		for (j = 0; j < 4; j = j + 1) e[8 * j +: 8] = 8'(ref_mem[adr + j]);
		cfg_rd(8'h04, 4'hF, rd);
		chk_reg(rd, e);
	endtask
	task automatic store(input [14:0] adr, input [31:0] d);
		integer j;
		integer w;
		w = storage_model_inst.n_writes;
		cfg_wr(8'h04, 4'hF, d);
		cfg_wr(8'h00, 4'hC, {1'b1, adr, 16'h0});
		poll(1'b0, adr);
		if (adr >= 15'd14) for (j = 0; j < 4; j = j + 1) ref_mem[adr + j] = d[8 * j +: 8];
		chk_mem(storage_model_inst.n_writes - w, (adr >= 15'd14) ? 4 : 0);
		for (j = 0; j < 4; j = j + 1) chk_mem(storage_model_inst.mem[adr + j], ref_mem[adr + j]);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ---
	// main sequence
	// ---
	initial begin
		reset_n_in = 1'b0;
		cfg_read_in = 1'b0;
		cfg_write_in = 1'b0;
		cfg_offset_in = 8'h00;
		cfg_byte_en_in = 4'h0;
		cfg_wdata_in = 32'h0;
		n_fail = 0;
		n_checks = 0;
		void'($urandom(2));
		repeat (12) @(negedge ref_clk_in);
		reset_n_in = 1'b1;
		for (i = 0; i < 64; i = i + 1) ref_mem.push_back(storage_model_inst.mem[i]);
		cfg_rd(8'h00, 4'hF, rd);
		chk_reg(rd, 32'h0000_0003);
		cfg_wr(8'h00, 4'h3, 32'hFFFF_FFFF);
		cfg_rd(8'h00, 4'h3, rd);
		chk_reg(rd, 32'h0000_0003);
		cfg_wr(8'h08, 4'hF, 32'hFFFF_FFFF);
		cfg_rd(8'h08, 4'hF, rd);
		chk_reg(rd, 32'h0000_0000);
		$display("test header done");
		i = 0;
		while (scan_done_out !== 1'b1 && i < 20000) begin
			@(negedge ref_clk_in);
			i = i + 1;
		end
		chk_reg({31'h0, content_valid_out}, 32'h1);
		wd = $urandom;
		cfg_wr(8'h04, 4'hF, 32'h0);
		cfg_wr(8'h04, 4'h5, wd);
		cfg_rd(8'h04, 4'hF, rd);
		chk_reg(rd, wd & 32'h00FF_00FF);
		cfg_rd(8'h04, 4'h4, rd);
		chk_reg(rd, wd & 32'h00FF_0000);
		cfg_rd(8'h04, 4'h1, rd);
		chk_reg(rd, wd & 32'h0000_00FF);
		cfg_wr(8'h00, 4'h4, 32'h0008_0000);
		repeat (3) cfg_rd(8'h00, 4'hF, rd);
		chk_reg(rd, 32'h0008_0003);
		chk_reg({31'h0, transfer_busy_out | ~sel_n}, 32'h0);
		$display("test window and side effects done");
		for (i = 0; i < 4; i = i + 1) fetch(15'(4 * i));
		fetch(15'd60);
		fetch(15'($urandom_range(15, 0) * 4));
		$display("test fetch done");
		store(15'd20, $urandom);
		store(15'd4, $urandom);
		store(15'd60, $urandom);
		fetch(15'd20);
		fetch(15'd60);
		$display("test store done");
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge ref_clk_in);
		n_fail = n_fail + 1;
		$display("ERROR %0t watchdog expired", $time);
		complete_run();
	end
endmodule
